// >>> rtl/lslb_consts.svh
// Constants for the limit status latch bank
`ifndef LSLB_CONSTS_SVH
`define LSLB_CONSTS_SVH
`define LSLB_DW 8
`define LSLB_NCH 7
`define LSLB_NVOLT 4
`define LSLB_NTEMP 3
`define LSLB_IDXW 8
`define LSLB_IDX_RUN 8'h40
`define LSLB_IDX_STAT1 8'h41
`define LSLB_IDX_STAT2 8'h42
`define LSLB_IDX_VEN 8'h7e
`define LSLB_IDX_TEN 8'h82
`define LSLB_IDX_IRQST 8'h90
`define LSLB_IDX_IRQMSK 8'h91
`define LSLB_IDX_COND 8'h92
`define LSLB_BIT_RUN 0
`define LSLB_BIT_SUM 7
`define LSLB_RST_BYTE 8'h00
`define LSLB_RST_RUN 1'b0
`define LSLB_RST_CH 7'h00
`define LSLB_RST_VEN 4'h0
`define LSLB_RST_TEN 3'h0
`define LSLB_ADR_LO 2
`define LSLB_ADR_HI 9
`define LSLB_ADR_TOP_LO 10
`endif

// >>> rtl/lslb_pkg.sv
// Types for the limit status latch bank
package lslb_pkg;
  typedef struct packed {
    logic [7:0] reading;
    logic [7:0] low_limit;
    logic [7:0] high_limit;
  } lslb_meas_t;
  typedef logic [6:0] lslb_chan_t;
endpackage : lslb_pkg

// >>> rtl/lslb_top.sv
// Limit status latch bank with classic Wishbone register slave
// Notes on behaviour
// - Temp enables at 82h, voltage at 7Eh
// - Flag sets only when enabled and violated
// - Set flag holds until read or disable
// - Read clears flags whose condition has gone
// - Global enable never touches flags; group enables clear at update
// - Bit 7 shows any second-bank flag set
// - Status register ignores writes entirely
// - Disabled flag never rises from 0
// - Disabled set flag clears at next update
// - Updates happen only while run bit set
// - Voltage violated when at/below low, above high
// - Temperature violated when at/below low, above high
// - No flag set while monitoring stopped
`include "lslb_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module lslb_top
  import lslb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire lslb_meas_t [`LSLB_NCH-1:0] meas_i,
  input wire lslb_chan_t meas_update_i,
  input wire logic [7:0] second_bank_flags_i,
  output logic second_bank_read_o,
  output logic monitor_run_o,
  output logic irq_o
);

  // Bus decode
  logic [`LSLB_IDXW-1:0] idx;
  logic top_zero;
  logic req;
  logic rd_req;
  logic wr_req;
  logic lane0;
  assign idx = adr_i[`LSLB_ADR_HI:`LSLB_ADR_LO];
  assign top_zero = (adr_i[31:`LSLB_ADR_TOP_LO] == 22'h000000);
  assign req = cyc_i && stb_i && !ack_o;
  assign rd_req = req && !we_i;
  assign wr_req = req && we_i && sel_i[0];
  assign lane0 = top_zero;

  logic hit_run;
  logic hit_stat1;
  logic hit_stat2;
  logic hit_ven;
  logic hit_ten;
  logic hit_irqst;
  logic hit_irqmsk;
  logic hit_cond;
  assign hit_run = lane0 && (idx == `LSLB_IDX_RUN);
  assign hit_stat1 = lane0 && (idx == `LSLB_IDX_STAT1);
  assign hit_stat2 = lane0 && (idx == `LSLB_IDX_STAT2);
  assign hit_ven = lane0 && (idx == `LSLB_IDX_VEN);
  assign hit_ten = lane0 && (idx == `LSLB_IDX_TEN);
  assign hit_irqst = lane0 && (idx == `LSLB_IDX_IRQST);
  assign hit_irqmsk = lane0 && (idx == `LSLB_IDX_IRQMSK);
  assign hit_cond = lane0 && (idx == `LSLB_IDX_COND);

  // Register write strobes
  logic wr_run;
  logic wr_ven;
  logic wr_ten;
  logic wr_msk;
  assign wr_run = wr_req && hit_run;
  assign wr_ven = wr_req && hit_ven;
  assign wr_ten = wr_req && hit_ten;
  assign wr_msk = wr_req && hit_irqmsk;

  // Control registers
  logic run;
  logic [`LSLB_NVOLT-1:0] volt_en;
  logic [`LSLB_NTEMP-1:0] temp_en;
  logic [`LSLB_NCH-1:0] irq_mask;
  logic next_run;
  logic [`LSLB_NVOLT-1:0] next_volt_en;
  logic [`LSLB_NTEMP-1:0] next_temp_en;
  logic [`LSLB_NCH-1:0] next_irq_mask;

  always_comb begin
    next_run = run;
    next_volt_en = volt_en;
    next_temp_en = temp_en;
    next_irq_mask = irq_mask;
    if (wr_run) begin
      next_run = dat_i[`LSLB_BIT_RUN];
    end
    if (wr_ven) begin
      next_volt_en = dat_i[`LSLB_NVOLT-1:0];
    end
    if (wr_ten) begin
      next_temp_en = dat_i[`LSLB_NTEMP-1:0];
    end
    if (wr_msk) begin
      next_irq_mask = dat_i[`LSLB_NCH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= `LSLB_RST_RUN;
      volt_en <= `LSLB_RST_VEN;
      temp_en <= `LSLB_RST_TEN;
      irq_mask <= `LSLB_RST_CH;
    end else begin
      run <= next_run;
      volt_en <= next_volt_en;
      temp_en <= next_temp_en;
      irq_mask <= next_irq_mask;
    end
  end

  assign monitor_run_o = run;

  // Per-channel enable, update and violation
  lslb_chan_t chan_en;
  lslb_chan_t upd;
  lslb_chan_t viol;
  lslb_chan_t flag;
  lslb_chan_t cond;
  logic stat1_rd;
  logic stat2_rd;
  // Flag order follows the enable register layout
  assign chan_en = {temp_en, volt_en};
  assign upd = meas_update_i & {`LSLB_NCH{run}};
  assign stat1_rd = rd_req && hit_stat1;
  assign stat2_rd = rd_req && hit_stat2;

  genvar k;
  generate
    for (k = 0; k < `LSLB_NCH; k = k + 1) begin : g_ch
      logic [`LSLB_DW-1:0] rdg;
      logic [`LSLB_DW-1:0] lo;
      logic [`LSLB_DW-1:0] hi;
      logic over;
      logic under;
      logic set_ev;
      logic off_clr;
      logic rd_clr;
      logic flag_bit;
      logic cond_bit;
      logic next_flag;
      logic next_cond;
      assign rdg = meas_i[k].reading;
      assign lo = meas_i[k].low_limit;
      assign hi = meas_i[k].high_limit;
      if (k < `LSLB_NVOLT) begin : g_volt
        // Supply readings compare unsigned
        assign under = rdg <= lo;
        assign over = rdg > hi;
      end else begin : g_temp
        // Temperatures compare as two's complement
        assign under = $signed(rdg) <= $signed(lo);
        assign over = $signed(rdg) > $signed(hi);
      end
      assign viol[k] = under || over;
      assign set_ev = upd[k] && chan_en[k] && viol[k];
      assign off_clr = upd[k] && !chan_en[k];
      assign rd_clr = stat1_rd && !cond_bit;

      // A set on the update beats a clearing read
      always_comb begin
        next_flag = flag_bit;
        next_cond = cond_bit;
        if (upd[k]) begin
          next_cond = viol[k];
        end
        if (set_ev) begin
          next_flag = 1'b1;
        end else if (off_clr) begin
          next_flag = 1'b0;
        end else if (rd_clr) begin
          next_flag = 1'b0;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flag_bit <= 1'b0;
          cond_bit <= 1'b0;
        end else begin
          flag_bit <= next_flag;
          cond_bit <= next_cond;
        end
      end

      assign flag[k] = flag_bit;
      assign cond[k] = cond_bit;
    end
  endgenerate

  // Interrupt status: rising flags are sticky events
  lslb_chan_t flag_q;
  lslb_chan_t irq_st;
  lslb_chan_t next_flag_q;
  lslb_chan_t next_irq_st;
  lslb_chan_t rise;
  logic irqst_rd;
  assign rise = flag & ~flag_q;
  assign irqst_rd = rd_req && hit_irqst;

  always_comb begin
    next_flag_q = flag;
    next_irq_st = irq_st;
    if (irqst_rd) begin
      next_irq_st = `LSLB_RST_CH;
    end
    // A rise in the same cycle wins over the clear
    next_irq_st = next_irq_st | rise;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= `LSLB_RST_CH;
      irq_st <= `LSLB_RST_CH;
    end else begin
      flag_q <= next_flag_q;
      irq_st <= next_irq_st;
    end
  end

  lslb_chan_t irq_pend;
  assign irq_pend = irq_st & irq_mask;
  assign irq_o = |irq_pend;

  // Read mux and acknowledge
  logic summary;
  logic [`LSLB_DW-1:0] rd_byte;
  logic [31:0] next_dat;
  logic next_ack;
  logic next_s2_rd;
  logic s2_rd;
  assign summary = |second_bank_flags_i;

  always_comb begin
    // Unmapped indices read as zero
    rd_byte = `LSLB_RST_BYTE;
    if (hit_run) begin
      rd_byte[`LSLB_BIT_RUN] = run;
    end
    if (hit_stat1) begin
      rd_byte[`LSLB_BIT_SUM] = summary;
      rd_byte[`LSLB_NCH-1:0] = flag;
    end
    if (hit_stat2) begin
      rd_byte = second_bank_flags_i;
    end
    if (hit_ven) begin
      rd_byte[`LSLB_NVOLT-1:0] = volt_en;
    end
    if (hit_ten) begin
      rd_byte[`LSLB_NTEMP-1:0] = temp_en;
    end
    if (hit_irqst) begin
      rd_byte[`LSLB_NCH-1:0] = irq_st;
    end
    if (hit_irqmsk) begin
      rd_byte[`LSLB_NCH-1:0] = irq_mask;
    end
    if (hit_cond) begin
      rd_byte[`LSLB_NCH-1:0] = cond;
    end
  end

  // Writes to status addresses only acknowledge
  always_comb begin
    // Every request is acknowledged one cycle later
    next_ack = req;
    next_dat = dat_o;
    next_s2_rd = stat2_rd;
    if (rd_req) begin
      next_dat = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      s2_rd <= 1'b0;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat;
      s2_rd <= next_s2_rd;
    end
  end

  assign second_bank_read_o = s2_rd;

endmodule : lslb_top
`default_nettype wire

// >>> verif/lslb_top_assertions.sv
// Port checker for the limit status latch bank
`timescale 1ns/100ps
`default_nettype none
module lslb_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [7:0] second_bank_flags_i,
  input wire logic second_bank_read_o,
  input wire logic monitor_run_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic rq;
  wire logic rd;
  assign rq = cyc_i && stb_i && !ack_o;
  assign rd = rq && !we_i;
  a_ack_next: assert property (rq |=> ack_o) else $error("no ack");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
  a_ack_cause: assert property (ack_o |-> $past(rq)) else $error("stray ack");
  a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper bits");
  a_sum_bit: assert property ($past(rd && adr_i == 32'h104) |->
    dat_o[7] == $past(|second_bank_flags_i)) else $error("summary");
  a_bank_read: assert property (second_bank_read_o |->
    ack_o && $past(rd && adr_i == 32'h108)) else $error("bank read");
  a_run_write: assert property ($changed(monitor_run_o) |->
    $past(rq && we_i && adr_i == 32'h100)) else $error("run change");
  a_unmapped: assert property ($past(rd && adr_i == 32'h3fc) |->
    dat_o == 32'h0) else $error("unmapped");
  c_sum: cover property (ack_o && dat_o[7]);
  c_bank: cover property (second_bank_read_o);
  c_run: cover property ($rose(monitor_run_o));
endmodule : lslb_chk
bind lslb_top lslb_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .second_bank_flags_i(second_bank_flags_i), .monitor_run_o(monitor_run_o),
  .second_bank_read_o(second_bank_read_o));
`default_nettype wire

// >>> verif/lslb_top_tb.sv
// Self-checking bench for the limit status latch bank
`timescale 1ns/100ps
`default_nettype none
module lslb_top_tb;
  import lslb_pkg::*;
  `define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin miscompares++;\
 $display("mismatch %s exp %h got %h", n, e, a); end end
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [31:0] adr_i = 0, dat_i = 0, dat_o, r = 32'h0592;
  logic [3:0] sel_i = 0;
  lslb_meas_t [6:0] meas_i = '0;
  lslb_chan_t up = '0;
  logic [7:0] sb = 0, q;
  logic [6:0] fl = 0, cd = 0, ist = 0, en = 0, old = 0, msk = 7'h7f;
  logic signed [8:0] a, l, h;
  logic ack_o, sbr, run_o, irq_o, run = 0, v, s2 = 0;
  int miscompares = 0, n_checks = 0, ch;
  always #5 clk_i = ~clk_i;
  lslb_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .meas_i(meas_i), .meas_update_i(up), .irq_o(irq_o),
    .second_bank_flags_i(sb), .second_bank_read_o(sbr), .monitor_run_o(run_o));
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lf
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    sel_i <= 4'h1;
    adr_i <= {22'h0, i, 2'b0};
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    s2 = sbr;
    cyc_i <= 0;
    stb_i <= 0;
    sel_i <= 0;
    @(posedge clk_i);
  endtask : wb
  initial begin #100000; miscompares++; results; end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 8'h41, 0);
    `CHK("stat1 reset", 8'h00, q)
    wb(0, 8'hff, 0);
    wb(1, 8'h91, 8'h7f);
    $display("test reset done");
    repeat (80) begin
      r = lf(r);
      sb <= r[31:24] & {8{r[27]}};
      case (r[30:28])
        0: begin wb(1, 8'h7e, r[3:0]); en[3:0] = r[3:0]; end
        1: begin wb(1, 8'h82, r[6:4]); en[6:4] = r[6:4]; end
        2: begin wb(1, 8'h40, r[7]); run = r[7]; end
        3: wb(1, 8'h41, r[7:0]);
        4: begin
          wb(0, 8'h42, 0);
          `CHK("stat2", sb, q)
          `CHK("bank read", 1'b1, s2)
        end
        5: begin wb(1, 8'h91, r[6:0]); msk = r[6:0]; end
        default: ;
      endcase
      ch = r[26:24] % 7;
      meas_i[ch] <= r[23:0];
      up <= 7'h1 << ch;
      a = {ch > 3 && r[23], r[23:16]};
      l = {ch > 3 && r[15], r[15:8]};
      h = {ch > 3 && r[7], r[7:0]};
      v = a <= l || a > h;
      old = fl;
      if (r[10]) begin
        fork
          wb(0, 8'h41, 0);
          begin @(posedge clk_i); up <= 0; end
        join
        `CHK("stat1 same cycle", {|sb, old}, q)
        fl &= cd;
      end else begin
        @(posedge clk_i);
        up <= 0;
      end
      if (run) begin
        cd[ch] = v;
        if (en[ch] && v && !old[ch]) ist[ch] = 1;
        if (en[ch] && v) fl[ch] = 1;
        else if (!en[ch]) fl[ch] = 0;
      end
      `CHK("run", run, run_o)
      if (!r[10]) begin
        repeat (2) @(posedge clk_i);
        wb(0, 8'h41, 0);
        `CHK("stat1", {|sb, fl}, q)
        `CHK("bank idle", 1'b0, s2)
        fl &= cd;
      end
      if (r[9]) begin
        wb(0, 8'h90, 0);
        `CHK("irq status", {1'b0, ist}, q)
        ist = 0;
      end
      `CHK("irq", |(ist & msk), irq_o)
    end
    $display("test random done");
    results;
  end
endmodule : lslb_top_tb
`default_nettype wire
